// File: logic/aircx_pkg.sv
// Shared constants, field layouts and carrier types of the alarm input and relay control block.
package aircx_pkg;
    localparam int ALARM_POINTS = 32;
    localparam int RELAY_POINTS = 16;
    localparam int DELAY_W = 10;
    localparam logic [DELAY_W-1:0] MAX_DELAY_S = 10'h3E7;
    localparam int CLK_HZ = 100_000_000;
    localparam int MS_PER_S = 1000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int MOM_MIN_MS = 200;
    // One extra tick because the first millisecond after a command is partial.
    localparam logic [7:0] MOM_TICKS = 8'(MOM_MIN_MS + 1);
    localparam int IDLE_S = 10800;

    // Word offsets on the register bus.
    localparam logic [7:0] OFS_STATE = 8'h00;
    localparam logic [7:0] OFS_RAW = 8'h04;
    localparam logic [7:0] OFS_CFG = 8'h08;
    localparam logic [7:0] OFS_SEL = 8'h0C;
    localparam logic [7:0] OFS_STAGE = 8'h10;
    localparam logic [7:0] OFS_LIVE = 8'h14;
    localparam logic [7:0] OFS_MOM = 8'h18;
    localparam logic [7:0] OFS_COMMIT = 8'h1C;
    localparam logic [7:0] OFS_CMD = 8'h20;
    localparam logic [7:0] OFS_RELAY = 8'h24;
    localparam logic [7:0] OFS_IRQ_ST = 8'h28;
    localparam logic [7:0] OFS_NOTIFY = 8'h2C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h30;
    localparam logic [7:0] OFS_RESULT = 8'h34;

    // Field positions.
    localparam int F_SEV_LO = 10;
    localparam int F_SA = 12;
    localparam int F_INV = 13;
    localparam int F_CMD_WANT = 4;
    localparam int F_CMD_SEEN = 5;
    localparam int IRQ_NOTIFY = 0;
    localparam int IRQ_REFUSED = 1;
    localparam int IRQ_DISCARD = 2;
    localparam int IRQ_COMMIT = 3;
    localparam int IRQ_W = 4;

    localparam logic [7:0] KEY_COMMIT = 8'hA5;
    localparam logic [7:0] KEY_UNDO = 8'h5A;
    localparam logic [1:0] RES_NONE = 2'h0;
    localparam logic [1:0] RES_DONE = 2'h1;
    localparam logic [1:0] RES_REFUSED = 2'h2;

    typedef enum logic [1:0] {
        critical_class = 2'b00,
        major_class = 2'b01,
        minor_class = 2'b10,
        status_class = 2'b11
    } aircx_sev_t;

    typedef struct packed {
        logic inv;
        logic sa;
        aircx_sev_t sev;
        logic [DELAY_W-1:0] delay;
    } aircx_point_t;

    localparam aircx_point_t POINT_RESET = '{inv: 1'b0, sa: 1'b0, sev: status_class, delay: 10'h000};

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } aircx_wb_req_t;

    typedef struct packed {
        logic [DELAY_W-1:0] cnt;
        logic q;
    } aircx_qual_st_t;
endpackage

// File: logic/aircx_qual.sv
// Per-point assertion delay qualifier counting whole-second ticks.
`timescale 1ns/1ps
module aircx_qual import aircx_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic tick_i,
    input wire logic asserted_i,
    input wire logic [DELAY_W-1:0] delay_i,
    output logic qual_o
);
    aircx_qual_st_t s_q;
    aircx_qual_st_t s_d;

    always_comb begin
        s_d = s_q;
        if (!asserted_i) begin
            s_d.cnt = '0;
            s_d.q = 1'b0;
        end else if (!s_q.q) begin
            if (delay_i == '0) begin
                s_d.q = 1'b1;
            end else if (tick_i) begin
                // The first tick may come at once, so delay+1 ticks guarantee the full delay.
                if (s_q.cnt == delay_i) begin
                    s_d.q = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt + 10'h001;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    assign qual_o = s_q.q;
endmodule // aircx_qual

// File: logic/aircx_top.sv
// Alarm input qualification, relay control and staged provisioning with a Wishbone register slave.
//
// Our own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module aircx_top import aircx_pkg::*; #(
    parameter int CYC_MS = CYC_PER_MS,
    parameter int MS_S = MS_PER_S,
    parameter int IDLE_SECONDS = IDLE_S
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire aircx_wb_req_t wb_req_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire logic [ALARM_POINTS-1:0] alarm_n_i,
    output logic [RELAY_POINTS-1:0] relay_o,
    output logic irq_o
);
    // All state apart from the qualifier counters lives in one record so that the clock enable freezes every field alike.
    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [ALARM_POINTS-1:0] sync1;
        logic [ALARM_POINTS-1:0] sync2;
        logic [16:0] ms_cnt;
        logic ms_tick;
        logic [9:0] s_cnt;
        logic s_tick;
        logic [ALARM_POINTS-1:0] qual_prev;
        aircx_point_t [ALARM_POINTS-1:0] live;
        aircx_point_t [ALARM_POINTS-1:0] stage;
        logic cfg_live;
        logic cfg_stage;
        logic [RELAY_POINTS-1:0] mom_live;
        logic [RELAY_POINTS-1:0] mom_stage;
        logic [4:0] sel_pt;
        logic [RELAY_POINTS-1:0] relay;
        logic [RELAY_POINTS-1:0][7:0] mom_cnt;
        logic [IRQ_W-1:0] irq_st;
        logic [IRQ_W-1:0] irq_mask;
        logic [ALARM_POINTS-1:0] notify;
        logic dirty;
        logic [13:0] idle_cnt;
        logic [1:0] result;
    } aircx_state_t;

    aircx_state_t s_q;
    aircx_state_t s_d;
    logic [ALARM_POINTS-1:0] asserted;
    logic [ALARM_POINTS-1:0] qual;
    logic [31:0] rd_word;

    // Byte-lane merge, so that a partial write leaves the other lanes untouched.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Status points stay silent unless the live status option is set.
    function automatic logic class_notifies(input aircx_sev_t sev, input logic status_opt);
        logic r;
        r = 1'b0;
        case (sev)
            critical_class: r = 1'b1;
            major_class: r = 1'b1;
            minor_class: r = 1'b1;
            status_class: r = status_opt;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // A grounded pin reads low after the two-flop synchroniser.
    always_comb begin
        for (int i = 0; i < ALARM_POINTS; i++) begin
            asserted[i] = s_q.sync2[i] ~^ s_q.live[i].inv;
        end
    end

    // One qualifier per point; each keeps its own count, so delays never interfere.
    genvar g;
    generate
        for (g = 0; g < ALARM_POINTS; g++) begin : g_qual
            aircx_qual u_qual (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .ce_i(ce_i),
                .tick_i(s_q.s_tick),
                .asserted_i(asserted[g]),
                .delay_i(s_q.live[g].delay),
                .qual_o(qual[g])
            );
        end
    endgenerate

    // Read word of the addressed register, captured into the state only when a request is taken.
    always_comb begin
        rd_word = 32'h0000_0000;
        case (wb_req_i.adr)
            OFS_STATE: rd_word = qual;
            OFS_RAW: rd_word = asserted;
            OFS_CFG: rd_word = {23'h00_0000, s_q.cfg_live, 7'h00, s_q.cfg_stage};
            OFS_SEL: rd_word = {27'h000_0000, s_q.sel_pt};
            OFS_STAGE: rd_word = {18'h0_0000, s_q.stage[s_q.sel_pt]};
            OFS_LIVE: rd_word = {18'h0_0000, s_q.live[s_q.sel_pt]};
            OFS_MOM: rd_word = {s_q.mom_live, s_q.mom_stage};
            OFS_COMMIT: rd_word = {31'h0000_0000, s_q.dirty};
            OFS_RELAY: rd_word = {16'h0000, s_q.relay};
            OFS_IRQ_ST: rd_word = {28'h000_0000, s_q.irq_st};
            OFS_NOTIFY: rd_word = s_q.notify;
            OFS_IRQ_MASK: rd_word = {28'h000_0000, s_q.irq_mask};
            OFS_RESULT: rd_word = {30'h0000_0000, s_q.result};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_comb begin
        logic req;
        logic wr;
        logic [31:0] wd;
        logic [31:0] tmp;
        logic [ALARM_POINTS-1:0] rise;
        logic [IRQ_W-1:0] ev;
        logic [3:0] pt;
        logic [DELAY_W-1:0] dl;
        aircx_point_t sp;
        logic commit;
        logic undo;
        req = 1'b0;
        wr = 1'b0;
        wd = 32'h0000_0000;
        tmp = 32'h0000_0000;
        rise = '0;
        ev = '0;
        pt = 4'h0;
        dl = '0;
        commit = 1'b0;
        undo = 1'b0;
        s_d = s_q;
        sp = s_q.stage[s_q.sel_pt];

        s_d.sync1 = alarm_n_i;
        s_d.sync2 = s_q.sync1;

        // Free-running ticks from the system clock.
        s_d.ms_tick = 1'b0;
        s_d.s_tick = 1'b0;
        if (s_q.ms_cnt == 17'(CYC_MS - 1)) begin
            s_d.ms_cnt = '0;
            s_d.ms_tick = 1'b1;
            if (s_q.s_cnt == 10'(MS_S - 1)) begin
                s_d.s_cnt = '0;
                s_d.s_tick = 1'b1;
            end else begin
                s_d.s_cnt = s_q.s_cnt + 10'h001;
            end
        end else begin
            s_d.ms_cnt = s_q.ms_cnt + 17'h0_0001;
        end

        // Bus answer one cycle after the request; writes act in the acknowledged cycle.
        req = wb_req_i.cyc && wb_req_i.stb;
        s_d.ack = req && !s_q.ack;
        wr = req && s_q.ack && wb_req_i.we;
        wd = wb_req_i.dat;
        if (s_d.ack) begin
            s_d.rdat = rd_word;
        end

        // Any bus activity keeps the staged changes alive.
        if (req) begin
            s_d.idle_cnt = '0;
        end else if (s_q.dirty && s_q.s_tick) begin
            s_d.idle_cnt = s_q.idle_cnt + 14'h0001;
        end

        // Momentary pulses age on millisecond ticks.
        for (int i = 0; i < RELAY_POINTS; i++) begin
            if (s_q.ms_tick && s_q.mom_cnt[i] != 8'h00) begin
                if (s_q.mom_cnt[i] == MOM_TICKS) begin
                    s_d.mom_cnt[i] = 8'h00;
                    s_d.relay[i] = 1'b0;
                end else begin
                    s_d.mom_cnt[i] = s_q.mom_cnt[i] + 8'h01;
                end
            end
        end

        if (wr) begin
            tmp = merge(32'h0000_0000, wd, wb_req_i.sel);
            case (wb_req_i.adr)
                OFS_CFG: begin
                    if (wb_req_i.sel[0]) begin
                        s_d.cfg_stage = wd[0];
                        s_d.dirty = 1'b1;
                    end
                end
                OFS_SEL: begin
                    if (wb_req_i.sel[0]) begin
                        s_d.sel_pt = wd[4:0];
                    end
                end
                OFS_STAGE: begin
                    tmp = merge({18'h0_0000, sp}, wd, wb_req_i.sel);
                    dl = tmp[DELAY_W-1:0];
                    // Values above the ceiling clamp rather than wrap, so a typo never becomes a short delay.
                    if (dl > MAX_DELAY_S) begin
                        dl = MAX_DELAY_S;
                    end
                    sp.delay = dl;
                    sp.sev = aircx_sev_t'(tmp[F_SEV_LO +: 2]);
                    sp.sa = tmp[F_SA];
                    sp.inv = tmp[F_INV];
                    s_d.stage[s_q.sel_pt] = sp;
                    s_d.dirty = 1'b1;
                end
                OFS_MOM: begin
                    tmp = merge({16'h0000, s_q.mom_stage}, wd, wb_req_i.sel);
                    s_d.mom_stage = tmp[RELAY_POINTS-1:0];
                    s_d.dirty = 1'b1;
                end
                OFS_COMMIT: begin
                    if (wb_req_i.sel[0]) begin
                        commit = (wd[7:0] == KEY_COMMIT);
                        undo = (wd[7:0] == KEY_UNDO);
                    end
                end
                OFS_CMD: begin
                    if (wb_req_i.sel[0]) begin
                        pt = wd[3:0];
                        // The requester states the relay level it saw; a mismatch means a stale view.
                        if (wd[F_CMD_SEEN] != s_q.relay[pt]) begin
                            s_d.result = RES_REFUSED;
                            ev[IRQ_REFUSED] = 1'b1;
                        end else begin
                            s_d.result = RES_DONE;
                            s_d.relay[pt] = wd[F_CMD_WANT];
                            s_d.mom_cnt[pt] = (wd[F_CMD_WANT] && s_q.mom_live[pt]) ? 8'h01 : 8'h00;
                        end
                    end
                end
                OFS_IRQ_ST: s_d.irq_st = s_q.irq_st & ~tmp[IRQ_W-1:0];
                OFS_NOTIFY: s_d.notify = s_q.notify & ~tmp;
                OFS_IRQ_MASK: begin
                    tmp = merge({28'h000_0000, s_q.irq_mask}, wd, wb_req_i.sel);
                    s_d.irq_mask = tmp[IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // Uncommitted staging times out after a long quiet spell.
        // A request in the expiry cycle wins, so a write that lands just then is kept.
        if (s_q.dirty && !req && s_q.idle_cnt >= 14'(IDLE_SECONDS)) begin
            undo = 1'b1;
            ev[IRQ_DISCARD] = 1'b1;
        end

        // Commit leaves qualifiers and relays running; a changed momentary bit affects later commands only.
        if (commit) begin
            s_d.live = s_q.stage;
            s_d.mom_live = s_q.mom_stage;
            s_d.cfg_live = s_q.cfg_stage;
            s_d.dirty = 1'b0;
            s_d.idle_cnt = '0;
            ev[IRQ_COMMIT] = 1'b1;
        end else if (undo) begin
            s_d.stage = s_q.live;
            s_d.mom_stage = s_q.mom_live;
            s_d.cfg_stage = s_q.cfg_live;
            s_d.dirty = 1'b0;
            s_d.idle_cnt = '0;
        end

        // Notifications on newly qualified points; a set in the clearing cycle wins.
        s_d.qual_prev = qual;
        for (int i = 0; i < ALARM_POINTS; i++) begin
            rise[i] = qual[i] && !s_q.qual_prev[i] && class_notifies(s_q.live[i].sev, s_q.cfg_live);
        end
        s_d.notify = s_d.notify | rise;
        ev[IRQ_NOTIFY] = |rise;
        s_d.irq_st = s_d.irq_st | ev;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            // Open pins idle high toward battery; starting the synchroniser there avoids a false alarm.
            s_q.sync1 <= '1;
            s_q.sync2 <= '1;
            s_q.live <= {ALARM_POINTS{POINT_RESET}};
            s_q.stage <= {ALARM_POINTS{POINT_RESET}};
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.rdat;
    assign relay_o = s_q.relay;
    // The interrupt is an OR of registered bits only, so it cannot glitch.
    assign irq_o = |(s_q.irq_st & s_q.irq_mask);
endmodule // aircx_top

// File: tb/aircx_station.sv
// Station side model: alarm contacts pulled to battery and relay-switched loads.
`timescale 1ns/1ps
module aircx_station import aircx_pkg::*; (
    input wire logic [ALARM_POINTS-1:0] ground_i,
    input wire logic [RELAY_POINTS-1:0] relay_i,
    output logic [ALARM_POINTS-1:0] alarm_n_o,
    output logic [RELAY_POINTS-1:0] load_no_o
);
    // An open contact floats up to battery, so the pin never shows a stale low.
    assign alarm_n_o = ~ground_i;
    // An energised relay closes common onto the normally-open contact.
    assign load_no_o = relay_i;
endmodule // aircx_station

// File: tb/aircx_top_monitor.sv
// Checker of bus handshake, relay and clock-enable behaviour at the top ports.
`timescale 1ns/1ps
module aircx_monitor import aircx_pkg::*; #(
    parameter int CYC_MS = CYC_PER_MS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire aircx_wb_req_t wb_req_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic [RELAY_POINTS-1:0] relay_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [31:0] on_cnt_q;
    logic [31:0] on_cnt_d;
    // Counts on-time of relay 0; a freeze by ce_i only lengthens the count.
    always_comb begin
        on_cnt_d = relay_o[0] ? on_cnt_q + 32'h1 : 32'h0;
    end
    always_ff @(posedge clk_i) begin
        on_cnt_q <= rst_i ? 32'h0 : on_cnt_d;
    end
    a_ack_next_cycle: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o && ce_i |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_one_pulse: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_req_i.cyc && wb_req_i.stb))
        else $error("ack without request");
    a_reset_quiet: assert property ($fell(rst_i) |-> relay_o == '0 && !irq_o && !wb_ack_o)
        else $error("outputs active after reset");
    a_data_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o)
        else $error("read data moved without ack");
    a_relay_rise_cmd: assert property (|(relay_o & ~$past(relay_o)) |->
        $past(wb_ack_o && wb_req_i.we && wb_req_i.adr == OFS_CMD))
        else $error("relay energised without command");
    a_pulse_length: assert property ($fell(relay_o[0]) && !$past(wb_ack_o) |->
        on_cnt_q >= 32'(MOM_MIN_MS * CYC_MS) && on_cnt_q <= 32'((MOM_MIN_MS + 2) * CYC_MS))
        else $error("momentary pulse length wrong");
    a_enable_freeze: assert property (!ce_i |=> $stable(relay_o) && $stable(wb_ack_o))
        else $error("state moved while disabled");
    c_cmd_write: cover property (wb_ack_o && wb_req_i.we && wb_req_i.adr == OFS_CMD);
    c_pulse_end: cover property ($fell(relay_o[0]) && !$past(wb_ack_o));
    c_irq_rise: cover property ($rose(irq_o));
endmodule // aircx_monitor

bind aircx_top aircx_monitor #(.CYC_MS(CYC_MS)) u_monitor (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_req_i(wb_req_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .relay_o(relay_o), .irq_o(irq_o));

// File: tb/alarm_input_and_relay_control_bench.sv
// Self-checking bench for alarm qualification, staging, notification and relays.
`timescale 1ns/1ps
module alarm_input_and_relay_control_bench import aircx_pkg::*;;
    localparam int CMS = 10;
    localparam int SEC = CMS * 5;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    aircx_wb_req_t req = '0;
    logic ack;
    logic [31:0] rdat;
    logic [ALARM_POINTS-1:0] gnd = '0;
    logic [ALARM_POINTS-1:0] pins;
    logic [RELAY_POINTS-1:0] relay;
    logic [RELAY_POINTS-1:0] load_no;
    logic irq;
    int bad_count = 0;
    int check_count = 0;
    int cyc_n = 0;
    always #5 clk_i = ~clk_i;
    aircx_top #(.CYC_MS(CMS), .MS_S(5), .IDLE_SECONDS(3)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .wb_req_i(req), .wb_ack_o(ack), .wb_dat_o(rdat), .alarm_n_i(pins), .relay_o(relay), .irq_o(irq));
    aircx_station u_station (.ground_i(gnd), .relay_i(relay), .alarm_n_o(pins), .load_no_o(load_no));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Holds the request until ack is sampled, then idles one cycle.
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        req <= '0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q & m, e);
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    initial begin
        waitc(5);
        rst_i <= 1'b0;
        waitc(1);
        rdc(OFS_STATE, 32'hFFFFFFFF, 32'h0);
        rdc(OFS_RAW, 32'hFFFFFFFF, 32'h0);
        wr(OFS_SEL, 32'h0);
        rdc(OFS_LIVE, 32'hFFFFFFFF, 32'h00000C00);
        rdc(8'hFC, 32'hFFFFFFFF, 32'h0);
        gnd[5] <= 1'b1;
        waitc(6);
        rdc(OFS_STATE, 32'h20, 32'h20);
        rdc(OFS_RAW, 32'h20, 32'h20);
        rdc(OFS_NOTIFY, 32'h20, 32'h0);
        ce_i <= 1'b0;
        waitc(4);
        ce_i <= 1'b1;
        wr(OFS_SEL, 32'h5);
        wr(OFS_STAGE, 32'h00002402);
        rdc(OFS_LIVE, 32'hFFFFFFFF, 32'h00000C00);
        wr(OFS_SEL, 32'h7);
        wr(OFS_STAGE, 32'h00000FFF);
        rdc(OFS_STAGE, 32'hFFFFFFFF, 32'h00000FE7);
        wr(OFS_CFG, 32'h1);
        wr(OFS_MOM, 32'h1);
        wr(OFS_IRQ_MASK, 32'h1);
        wr(OFS_COMMIT, 32'h000000A5);
        rdc(OFS_IRQ_ST, 32'h8, 32'h8);
        wr(OFS_SEL, 32'h5);
        rdc(OFS_LIVE, 32'hFFFFFFFF, 32'h00002402);
        rdc(OFS_CFG, 32'h101, 32'h101);
        rdc(OFS_MOM, 32'hFFFFFFFF, 32'h00010001);
        rdc(OFS_IRQ_MASK, 32'hF, 32'h1);
        // Inverted point with a two second delay; a short re-ground restarts the count.
        gnd[5] <= 1'b0;
        waitc(80);
        gnd[5] <= 1'b1;
        waitc(5);
        gnd[5] <= 1'b0;
        waitc(80);
        rdc(OFS_STATE, 32'h20, 32'h0);
        chk({31'h0, irq}, 32'h0);
        waitc(80);
        rdc(OFS_STATE, 32'h20, 32'h20);
        rdc(OFS_NOTIFY, 32'h20, 32'h20);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_IRQ_ST, 32'hF);
        wr(OFS_NOTIFY, 32'hFFFFFFFF);
        chk({31'h0, irq}, 32'h0);
        // Re-grounding the inverted point drops its state at once.
        gnd[5] <= 1'b1;
        waitc(4);
        rdc(OFS_STATE, 32'h20, 32'h0);
        gnd[6] <= 1'b1;
        waitc(6);
        rdc(OFS_NOTIFY, 32'h40, 32'h40);
        wr(OFS_CMD, 32'h12);
        chk({16'h0, load_no}, 32'h4);
        rdc(OFS_RESULT, 32'h3, 32'h1);
        wr(OFS_CMD, 32'h02);
        rdc(OFS_RESULT, 32'h3, 32'h2);
        rdc(OFS_RELAY, 32'hFFFF, 32'h4);
        rdc(OFS_IRQ_ST, 32'h2, 32'h2);
        wr(OFS_CMD, 32'h22);
        wr(OFS_CMD, 32'h1F);
        rdc(OFS_RELAY, 32'hFFFF, 32'h8000);
        wr(OFS_CMD, 32'h10);
        waitc(1990);
        chk({16'h0, load_no}, 32'h8001);
        waitc(30);
        chk({16'h0, load_no}, 32'h8000);
        wr(OFS_SEL, 32'h8);
        wr(OFS_STAGE, 32'h1);
        wr(OFS_COMMIT, 32'h0000005A);
        rdc(OFS_COMMIT, 32'h1, 32'h0);
        wr(OFS_STAGE, 32'h1);
        rdc(OFS_COMMIT, 32'h1, 32'h1);
        waitc(5 * SEC);
        rdc(OFS_COMMIT, 32'h1, 32'h0);
        rdc(OFS_IRQ_ST, 32'h4, 32'h4);
        tally_and_finish();
    end
endmodule // alarm_input_and_relay_control_bench
